// file: src/deac_top.sv
// Data EEPROM access controller: register interface, unlock sequencer, timed write, storage
`timescale 1ns/10ps
`default_nettype none
`include "deac_map.svh"

module deac_top
  import deac_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `DEAC_WRITE_CYCLES
)(
  input  wire logic          i_sys_clk,
  input  wire logic          i_resetn,
  input  wire deac_sfr_req_t i_sfr,
  output logic [7:0]         o_sfr_rdata,
  input  wire logic          i_external_reset_pin,
  input  wire logic          i_watchdog_timer,
  input  wire logic          i_brownout_detect,
  input  wire logic          i_done_flag_clr,
  output logic               o_program_done_flag,
  input  wire logic          i_code_protect,
  input  wire logic          i_prog_rd,
  input  wire logic          i_prog_wr,
  input  wire logic [6:0]    i_prog_addr,
  input  wire logic [7:0]    i_prog_wdata,
  output logic [7:0]         o_prog_rdata
);

  // ========================================================================================
  // Abort source synchronisers
  logic [2:0] src_raw;
  logic [2:0] sync1, sync2, sync3, filt;
  logic [2:0] next_filt;
  logic       any_abort;

  assign src_raw   = {i_brownout_detect, i_watchdog_timer, i_external_reset_pin};
  assign any_abort = |filt;

  // Level only counts once the second and third stages agree
  genvar gs;
  generate
    for (gs = 0; gs < 3; gs++)
    begin : g_sync
      assign next_filt[gs] = (sync2[gs] == sync3[gs]) ? sync3[gs] : filt[gs];
    end
  endgenerate

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
      filt  <= 3'h0;
    end
    else
    begin
      sync1 <= src_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= next_filt;
    end
  end

  // ========================================================================================
  // Register-space decode
  function automatic logic wr_hit(input deac_sfr_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction : wr_hit

  // ========================================================================================
  // Storage: flip-flops, not reset since the cells are nonvolatile
  logic [7:0] mem [`DEAC_DEPTH];
  logic [7:0] next_mem [`DEAC_DEPTH];
  logic       mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wval;

  genvar gm;
  generate
    for (gm = 0; gm < `DEAC_DEPTH; gm++)
    begin : g_mem
      assign next_mem[gm] = (mem_we && mem_waddr == 7'(gm)) ? mem_wval : mem[gm];
      always_ff @(posedge i_sys_clk)
      begin
        mem[gm] <= next_mem[gm];
      end
    end
  endgenerate

  // ========================================================================================
  // Control state
  deac_state_t state, next_state;
  logic [3:0]  gap_cnt, next_gap_cnt;
  logic [15:0] timer, next_timer;
  logic [7:0]  data_q, next_data_q;
  logic [6:0]  loc_q, next_loc_q;
  logic [6:0]  wr_addr, next_wr_addr;
  logic [7:0]  wr_data, next_wr_data;
  logic        rd_q, next_rd_q;
  logic        wr_q, next_wr_q;
  logic        permit_q, next_permit_q;
  logic        abort_q, next_abort_q;
  logic        done_q, next_done_q;
  logic        done_set;

  always_comb
  begin
    next_state    = state;
    next_gap_cnt  = gap_cnt;
    next_timer    = timer;
    next_data_q   = data_q;
    next_loc_q    = loc_q;
    next_wr_addr  = wr_addr;
    next_wr_data  = wr_data;
    next_rd_q     = rd_q;
    next_wr_q     = wr_q;
    next_permit_q = permit_q;
    next_abort_q  = abort_q;
    done_set      = 1'b0;
    // Programmer port writes only when unprotected and no timed write runs
    mem_we        = i_prog_wr && !i_code_protect && state != ST_WRITE;
    mem_waddr     = i_prog_addr;
    mem_wval      = i_prog_wdata;

    if (any_abort)
    begin
      // Reset-class event: the location stays erased, software must retry
      if (state == ST_WRITE)
        next_abort_q = 1'b1;
      next_data_q   = 8'h00;
      next_loc_q    = 7'h00;
      next_rd_q     = 1'b0;
      next_wr_q     = 1'b0;
      next_permit_q = 1'b0;
      next_timer    = 16'h0000;
      next_state    = ST_IDLE;
    end
    else
    begin
      // Read trigger stands one cycle only
      if (rd_q)
        next_rd_q = 1'b0;
      // Plain register writes
      if (wr_hit(i_sfr, `DEAC_ADDR_DATA))
        next_data_q = i_sfr.wdata;
      if (wr_hit(i_sfr, `DEAC_ADDR_LOC))
        next_loc_q = i_sfr.wdata[6:0];
      if (wr_hit(i_sfr, `DEAC_ADDR_CTRL))
      begin
        next_permit_q = i_sfr.wdata[`DEAC_BIT_PERMIT];
        next_abort_q  = i_sfr.wdata[`DEAC_BIT_ABORT];
        // Fetch with the trigger so a read strobe in the next cycle sees the byte
        if (i_sfr.wdata[`DEAC_BIT_RD])
        begin
          next_rd_q   = 1'b1;
          next_data_q = mem[loc_q];
        end
      end

      // Unlock sequencer: each step must come exactly the gap after the last
      case (state)
        ST_IDLE:
        begin
          if (wr_hit(i_sfr, `DEAC_ADDR_UNLOCK) && i_sfr.wdata == `DEAC_KEY1)
          begin
            next_state   = ST_KEY1;
            next_gap_cnt = 4'h1;
          end
        end
        ST_KEY1:
        begin
          next_gap_cnt = gap_cnt + 4'h1;
          if (i_sfr.wr || gap_cnt == `DEAC_UNLOCK_GAP)
            next_state = ST_IDLE;
          if (wr_hit(i_sfr, `DEAC_ADDR_UNLOCK) && i_sfr.wdata == `DEAC_KEY2
              && gap_cnt == `DEAC_UNLOCK_GAP)
          begin
            next_state   = ST_KEY2;
            next_gap_cnt = 4'h1;
          end
        end
        ST_KEY2:
        begin
          next_gap_cnt = gap_cnt + 4'h1;
          if (i_sfr.wr || gap_cnt == `DEAC_UNLOCK_GAP)
            next_state = ST_IDLE;
          // Trigger refused unless permit was already set
          if (wr_hit(i_sfr, `DEAC_ADDR_CTRL) && i_sfr.wdata[`DEAC_BIT_WR]
              && permit_q && gap_cnt == `DEAC_UNLOCK_GAP)
          begin
            next_state   = ST_WRITE;
            next_wr_q    = 1'b1;
            next_timer   = 16'h0000;
            next_wr_addr = loc_q;
            next_wr_data = data_q;
            // Erase first; programming happens at timer expiry
            mem_we       = 1'b1;
            mem_waddr    = loc_q;
            mem_wval     = `DEAC_ERASED;
          end
        end
        ST_WRITE:
        begin
          // Permit may drop now without affecting this write
          next_timer = timer + 16'h0001;
          if (timer == 16'(WRITE_CYCLES - 1))
          begin
            mem_we       = 1'b1;
            mem_waddr    = wr_addr;
            mem_wval     = wr_data;
            next_wr_q    = 1'b0;
            done_set     = 1'b1;
            next_abort_q = 1'b0;
            next_state   = ST_IDLE;
          end
        end
        default:
        begin
          next_state = ST_IDLE;
        end
      endcase
    end
    // Set wins over a clear arriving the same cycle
    next_done_q = done_set | (done_q & ~i_done_flag_clr);
  end

  // Power-up leaves permit and abort clear
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      state    <= ST_IDLE;
      gap_cnt  <= 4'h0;
      timer    <= 16'h0000;
      data_q   <= 8'h00;
      loc_q    <= 7'h00;
      wr_addr  <= 7'h00;
      wr_data  <= 8'h00;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      permit_q <= 1'b0;
      abort_q  <= 1'b0;
      done_q   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      gap_cnt  <= next_gap_cnt;
      timer    <= next_timer;
      data_q   <= next_data_q;
      loc_q    <= next_loc_q;
      wr_addr  <= next_wr_addr;
      wr_data  <= next_wr_data;
      rd_q     <= next_rd_q;
      wr_q     <= next_wr_q;
      permit_q <= next_permit_q;
      abort_q  <= next_abort_q;
      done_q   <= next_done_q;
    end
  end

  // ========================================================================================
  // Read-back paths, registered
  logic [7:0] next_sfr_rdata, next_prog_rdata;

  always_comb
  begin
    next_sfr_rdata = o_sfr_rdata;
    if (i_sfr.rd)
    begin
      case (i_sfr.addr)
        `DEAC_ADDR_DATA:   next_sfr_rdata = data_q;
        `DEAC_ADDR_LOC:    next_sfr_rdata = {1'b0, loc_q};
        `DEAC_ADDR_CTRL:   next_sfr_rdata = {4'h0, abort_q, permit_q, wr_q, rd_q};
        `DEAC_ADDR_UNLOCK: next_sfr_rdata = 8'h00;
        default:           next_sfr_rdata = 8'h00;
      endcase
    end
    next_prog_rdata = o_prog_rdata;
    if (i_prog_rd)
      next_prog_rdata = i_code_protect ? 8'h00 : mem[i_prog_addr];
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      o_sfr_rdata  <= 8'h00;
      o_prog_rdata <= 8'h00;
    end
    else
    begin
      o_sfr_rdata  <= next_sfr_rdata;
      o_prog_rdata <= next_prog_rdata;
    end
  end

  assign o_program_done_flag = done_q;

endmodule : deac_top
`default_nettype wire

// file: src/deac_map.svh
// Register offsets, bit positions and timing constants for the data EEPROM access controller
// ==========================================================================================
`ifndef DEAC_MAP_SVH
`define DEAC_MAP_SVH

// ==========================================================================================
// Register space
`define DEAC_ADDR_DATA     8'h9a
`define DEAC_ADDR_LOC      8'h9b
`define DEAC_ADDR_CTRL     8'h9c
`define DEAC_ADDR_UNLOCK   8'h9d
`define DEAC_BIT_RD        0
`define DEAC_BIT_WR        1
`define DEAC_BIT_PERMIT    2
`define DEAC_BIT_ABORT     3

// ==========================================================================================
// Storage and unlock
`define DEAC_DEPTH         128
`define DEAC_ERASED        8'hff
`define DEAC_KEY1          8'h55
`define DEAC_KEY2          8'haa
`define DEAC_UNLOCK_GAP    4'h2

// ==========================================================================================
// Timing
`define DEAC_CLK_MHZ       10
`define DEAC_WRITE_TIME_US 5000
`define DEAC_WRITE_CYCLES  (`DEAC_WRITE_TIME_US * `DEAC_CLK_MHZ)

`endif

// file: src/deac_pkg.sv
// Types shared by the data EEPROM access controller
package deac_pkg;

  // Register-space request from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } deac_sfr_req_t;

  // Unlock and write sequencer
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_KEY1  = 4'b0010,
    ST_KEY2  = 4'b0100,
    ST_WRITE = 4'b1000
  } deac_state_t;

endpackage : deac_pkg

// file: tb/deac_top_chk.sv
// Port-level assertions for the data EEPROM access controller
`timescale 1ns/10ps
`default_nettype none
module deac_top_chk
  import deac_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = 20
)(
  input wire logic          i_sys_clk,
  input wire logic          i_resetn,
  input wire deac_sfr_req_t i_sfr,
  input wire logic [7:0]    o_sfr_rdata,
  input wire logic          i_external_reset_pin,
  input wire logic          i_watchdog_timer,
  input wire logic          i_brownout_detect,
  input wire logic          i_done_flag_clr,
  input wire logic          o_program_done_flag,
  input wire logic          i_code_protect,
  input wire logic          i_prog_rd,
  input wire logic [7:0]    o_prog_rdata
);
  // ==========================================================
  // Expected write timer, armed only by a clean unlock sequence
  deac_sfr_req_t h1, h2, h3, h4;
  int            wcnt;
  int            next_wcnt;

  // Abort sources drop the model at once; the design lags a few edges
  always_comb
  begin
    next_wcnt = (wcnt > 0) ? wcnt - 1 : 0;
    if (i_sfr.wr && i_sfr.addr == 8'h9c && i_sfr.wdata[2:1] == 2'b11 && !h1.wr && !h3.wr
        && h2 == {2'b10, 8'h9d, 8'haa} && h4 == {2'b10, 8'h9d, 8'h55})
      next_wcnt = int'(WRITE_CYCLES);
    if (!i_resetn || i_external_reset_pin || i_watchdog_timer || i_brownout_detect)
      next_wcnt = 0;
  end

  // History of register requests
  always_ff @(posedge i_sys_clk)
  begin
    wcnt <= next_wcnt;
    h1   <= i_sfr;
    h2   <= h1;
    h3   <= h2;
    h4   <= h3;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  a_rdata_holds: assert property (!i_sfr.rd |=> $stable(o_sfr_rdata))
    else $error("read data moved without a read");
  a_unlock_zero: assert property (i_sfr.rd && i_sfr.addr == 8'h9d |=> o_sfr_rdata == 8'h00)
    else $error("unlock port read not zero");
  a_unmapped_zero: assert property (i_sfr.rd && !(i_sfr.addr inside {[8'h9a:8'h9d]}) |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_upper: assert property (i_sfr.rd && i_sfr.addr == 8'h9c |=> o_sfr_rdata[7:4] == 4'h0)
    else $error("control upper bits not zero");
  a_loc_msb: assert property (i_sfr.rd && i_sfr.addr == 8'h9b |=> !o_sfr_rdata[7])
    else $error("address bit 7 read as one");
  a_done_sticky: assert property (o_program_done_flag && !i_done_flag_clr |=> o_program_done_flag)
    else $error("done flag dropped without clear");
  a_prog_blocked: assert property (i_prog_rd && i_code_protect |=> o_prog_rdata == 8'h00)
    else $error("programmer read while protected");
  a_no_early_done: assert property (wcnt > 2 |-> !o_program_done_flag)
    else $error("write ended early");
  a_done_on_time: assert property (wcnt == 1 |=> ##[0:1] o_program_done_flag)
    else $error("write did not end on time");
endmodule : deac_top_chk

bind deac_top deac_top_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_deac_top_chk (.i_sys_clk, .i_resetn, .i_sfr,
  .o_sfr_rdata, .i_external_reset_pin, .i_watchdog_timer, .i_brownout_detect, .i_done_flag_clr,
  .o_program_done_flag, .i_code_protect, .i_prog_rd, .o_prog_rdata);
`default_nettype wire

// file: tb/deac_top_tb.sv
// Self-checking bench for the data EEPROM access controller
`timescale 1ns/10ps
`default_nettype none
module deac_top_tb
  import deac_pkg::*;
;
  localparam int unsigned WC = 20;
  logic          i_sys_clk = 1'b0;
  logic          i_resetn = 1'b0;
  deac_sfr_req_t i_sfr = '0;
  logic          i_external_reset_pin = 1'b0, i_watchdog_timer = 1'b0, i_brownout_detect = 1'b0;
  logic          i_done_flag_clr = 1'b0, i_code_protect = 1'b0, i_prog_rd = 1'b0, i_prog_wr = 1'b0;
  logic [6:0]    i_prog_addr = 7'h00;
  logic [7:0]    i_prog_wdata = 8'h00;
  logic [7:0]    o_sfr_rdata, o_prog_rdata, v, d;
  logic [7:0]    exp_mem [128];
  logic          o_program_done_flag;
  logic [31:0]   seed = 32'hdc148fa0;
  logic [31:0]   r;
  logic [6:0]    a;
  int            bad_count = 0, comparisons = 0;

  always #50 i_sys_clk = ~i_sys_clk;

  deac_top #(.WRITE_CYCLES(WC)) u_deac_top (.i_sys_clk, .i_resetn, .i_sfr, .o_sfr_rdata, .i_external_reset_pin,
    .i_watchdog_timer, .i_brownout_detect, .i_done_flag_clr, .o_program_done_flag, .i_code_protect, .i_prog_rd,
    .i_prog_wr, .i_prog_addr, .i_prog_wdata, .o_prog_rdata);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [7:0] ctl(input logic ab, input logic pm, input logic w);
    return {4'h0, ab, pm, w, 1'b0};
  endfunction : ctl
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk) #1;
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    comparisons++;
    if (got !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  // Strobe is left high so back-to-back writes need no gap
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    i_sfr = '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: dt};
    cyc(1);
  endtask : wr
  task automatic gap(input int n);
    i_sfr = '0;
    cyc(n);
  endtask : gap
  task automatic rd(input logic [7:0] ad);
    i_sfr = '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    cyc(1);
    v = o_sfr_rdata;
    gap(1);
  endtask : rd
  task automatic prd(input logic [6:0] ad);
    i_prog_addr = ad;
    i_prog_rd = 1'b1;
    cyc(1);
    i_prog_rd = 1'b0;
    v = o_prog_rdata;
  endtask : prd
  task automatic eeread(input logic [7:0] ad);
    wr(8'h9b, ad);
    wr(8'h9c, 8'h01);
    rd(8'h9a);
  endtask : eeread
  // Unlock with a chosen key spacing and final control value
  task automatic start(input logic [6:0] ad, input logic [7:0] dt, input int g, input logic [7:0] c);
    wr(8'h9b, {1'b0, ad});
    wr(8'h9a, dt);
    wr(8'h9c, c & 8'h04);
    wr(8'h9d, 8'h55);
    gap(g - 1);
    wr(8'h9d, 8'haa);
    gap(1);
    wr(8'h9c, c);
    gap(1);
  endtask : start
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Watchdog
  initial
  begin
    repeat (6000) @(posedge i_sys_clk);
    bad_count++;
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial
  begin : main
    int k;
    int s;
    cyc(2);
    i_resetn = 1'b1;
    // Reset values, unlock port and one unmapped place
    for (k = 0; k < 5; k++)
    begin
      rd(8'h9a + 8'(k));
      chk(v, 8'h00);
    end
    // Random writes with corner data, protection toggled
    for (k = 0; k < 6; k++)
    begin
      r = xs();
      a = {1'b0, r[5:0]};
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : r[15:8];
      i_code_protect = k[0];
      start(a, d, 2, 8'h06);
      i_prog_wdata = ~d;
      i_prog_wr = 1'b1;
      prd(a);
      i_prog_wr = 1'b0;
      chk(v, i_code_protect ? 8'h00 : 8'hff);
      rd(8'h9c);
      chk(v, ctl(1'b0, 1'b1, 1'b1));
      wr(8'h9c, 8'h00);
      rd(8'h9c);
      chk(v, ctl(1'b0, 1'b0, 1'b1));
      for (s = 0; s < WC + 10 && o_program_done_flag !== 1'b1; s++)
        cyc(1);
      chk({7'h00, o_program_done_flag}, 8'h01);
      rd(8'h9c);
      chk(v, ctl(1'b0, 1'b0, 1'b0));
      exp_mem[a] = d;
      i_done_flag_clr = 1'b1;
      cyc(1);
      i_done_flag_clr = 1'b0;
      cyc(1);
      chk({7'h00, o_program_done_flag}, 8'h00);
      eeread({1'b1, a});
      chk(v, d);
      rd(8'h9b);
      chk(v, {1'b0, a});
    end
    // Programmer write lands when unprotected and idle
    i_code_protect = 1'b0;
    i_prog_addr = a;
    i_prog_wdata = 8'h96;
    i_prog_wr = 1'b1;
    cyc(1);
    i_prog_wr = 1'b0;
    prd(a);
    chk(v, 8'h96);
    exp_mem[a] = 8'h96;
    // Bad key spacing, then missing permit
    for (k = 0; k < 2; k++)
    begin
      start(a, 8'h3c, 3 - k, (k == 0) ? 8'h06 : 8'h02);
      rd(8'h9c);
      chk(v, ctl(1'b0, k == 0, 1'b0));
      cyc(WC + 4);
      chk({7'h00, o_program_done_flag}, 8'h00);
      eeread({1'b0, a});
      chk(v, exp_mem[a]);
    end
    // Each abort source cuts a running write
    for (s = 0; s < 3; s++)
    begin
      start(7'h7d + 7'(s), 8'h5a, 2, 8'h06);
      cyc(4);
      {i_external_reset_pin, i_watchdog_timer, i_brownout_detect} = 3'b100 >> s;
      cyc(5);
      {i_external_reset_pin, i_watchdog_timer, i_brownout_detect} = 3'b000;
      cyc(6);
      rd(8'h9c);
      chk(v, ctl(1'b1, 1'b0, 1'b0));
      chk({7'h00, o_program_done_flag}, 8'h00);
      rd(8'h9a);
      chk(v, 8'h00);
      rd(8'h9b);
      chk(v, 8'h00);
      wr(8'h9c, 8'h00);
      rd(8'h9c);
      chk(v, 8'h00);
    end
    wrap_up();
  end
endmodule : deac_top_tb
`default_nettype wire
